// *** inc/xofd_defs.vh ***
// constants for the operand field decoder
`ifndef XOFD_DEFS_VH
`define XOFD_DEFS_VH
// operand / register sizes
`define XOFD_SZ_NONE 2'h0
`define XOFD_SZ_8 2'h1
`define XOFD_SZ_16 2'h2
`define XOFD_SZ_32 2'h3
// displacement / immediate lengths
`define XOFD_LEN_0 2'h0
`define XOFD_LEN_8 2'h1
`define XOFD_LEN_16 2'h2
`define XOFD_LEN_32 2'h3
// addressing field positions
`define XOFD_MOD_HI 7
`define XOFD_MOD_LO 6
`define XOFD_REG_HI 5
`define XOFD_REG_LO 3
`define XOFD_RM_HI 2
`define XOFD_RM_LO 0
// mod codes
`define XOFD_MOD_NODISP 2'h0
`define XOFD_MOD_DISP8 2'h1
`define XOFD_MOD_DISPW 2'h2
`define XOFD_MOD_REG 2'h3
// special r/m codes
`define XOFD_RM16_DIRECT 3'h6
`define XOFD_RM32_DIRECT 3'h5
`define XOFD_RM32_SIB 3'h4
// general register codes
`define XOFD_GR_BX 3'h3
`define XOFD_GR_BP 3'h5
`define XOFD_GR_SI 3'h6
`define XOFD_GR_DI 3'h7
// special register classes
`define XOFD_CLS_CTRL 2'h0
`define XOFD_CLS_DBG 2'h1
`define XOFD_CLS_TEST 2'h2
// reset value of all outputs
`define XOFD_RST_1 1'h0
`define XOFD_RST_3 3'h0
`define XOFD_RST_2 2'h0
`endif

// *** verilog/xofd_decoder.v ***
// operand field decoder: mod r/m, reg, immediate and special registers
`timescale 1ns/10ps
`default_nettype none
// Contract
// - s bit selects sign-extended 8-bit immediate
// - special MOV uses 3-bit select per class
// - select codes map to CR, DR, TR
// - unlisted select codes flagged invalid
// - mod and r/m pick addressing; fixed none
// - 16-bit forms, r/m 110 direct d16
// - 16-bit BP forms use stack segment
// - 32-bit base from r/m, 101 direct
// - 32-bit disp 8 for 01, 32 for 10
// - 32-bit r/m 100 expects sib byte
// - mod 11 selects register by width bit
// - reg field uses same width rules
// - no width bit gives full-size register
// - width bit 0 means 8-bit operand
// - direction bit picks source operand
`include "xofd_defs.vh"
module xofd_decoder (
	// clock and reset
	input wire core_clk,
	input wire resetn,
	// request from prefetch
	input wire in_valid,
	input wire [7:0] modrm,
	input wire has_modrm,
	input wire op32,
	input wire addr32,
	input wire w_present,
	input wire w_bit,
	input wire d_bit,
	input wire s_bit,
	input wire has_imm,
	input wire spec_mov,
	input wire [1:0] spec_class,
	// decoded result
	output reg out_valid,
	output reg rm_is_reg,
	output reg [2:0] rm_reg,
	output reg [1:0] rm_size,
	output reg [2:0] reg_sel,
	output reg [1:0] reg_size,
	output reg [1:0] op_size,
	output reg base_valid,
	output reg [2:0] base_reg,
	output reg index_valid,
	output reg [2:0] index_reg,
	output reg direct_addr,
	output reg seg_stack,
	output reg sib_expected,
	output reg [1:0] disp_len,
	output reg [1:0] imm_len,
	output reg imm_sext,
	output reg src_is_rm,
	output reg spec_valid,
	output reg [2:0] spec_num,
	output reg spec_invalid
);

// size of a general register selection
function [1:0] gr_size;
	input wp;
	input w;
	input o32;
	begin
		if (wp && !w) begin
			gr_size = `XOFD_SZ_8;
		end else if (o32) begin
			gr_size = `XOFD_SZ_32;
		end else begin
			gr_size = `XOFD_SZ_16;
		end
	end
endfunction

// validity of a special register select code
function spec_ok;
	input [1:0] cls;
	input [2:0] code;
	begin
		case (cls)
			`XOFD_CLS_CTRL: begin
				spec_ok = (code == 3'h0) || (code == 3'h2) ||
					(code == 3'h3) || (code == 3'h4);
			end
			`XOFD_CLS_DBG: begin
				spec_ok = (code != 3'h4) && (code != 3'h5);
			end
			`XOFD_CLS_TEST: begin
				spec_ok = (code >= 3'h3);
			end
			default: begin
				spec_ok = 1'b0;
			end
		endcase
	end
endfunction

// field split
wire [1:0] f_mod;
wire [2:0] f_reg;
wire [2:0] f_rm;
assign f_mod = modrm[`XOFD_MOD_HI:`XOFD_MOD_LO];
assign f_reg = modrm[`XOFD_REG_HI:`XOFD_REG_LO];
assign f_rm = modrm[`XOFD_RM_HI:`XOFD_RM_LO];

// next-state values
reg rm_is_reg_d;
reg [2:0] rm_reg_d;
reg [1:0] rm_size_d;
reg [2:0] reg_sel_d;
reg [1:0] reg_size_d;
reg [1:0] op_size_d;
reg base_valid_d;
reg [2:0] base_reg_d;
reg index_valid_d;
reg [2:0] index_reg_d;
reg direct_addr_d;
reg seg_stack_d;
reg sib_expected_d;
reg [1:0] disp_len_d;
reg [1:0] imm_len_d;
reg imm_sext_d;
reg src_is_rm_d;
reg spec_valid_d;
reg [2:0] spec_num_d;
reg spec_invalid_d;
reg mem_form;

always @* begin
	rm_is_reg_d = 1'b0;
	rm_reg_d = `XOFD_RST_3;
	rm_size_d = `XOFD_SZ_NONE;
	base_valid_d = 1'b0;
	base_reg_d = `XOFD_RST_3;
	index_valid_d = 1'b0;
	index_reg_d = `XOFD_RST_3;
	direct_addr_d = 1'b0;
	seg_stack_d = 1'b0;
	sib_expected_d = 1'b0;
	disp_len_d = `XOFD_LEN_0;
	mem_form = has_modrm && (f_mod != `XOFD_MOD_REG);
	op_size_d = gr_size(w_present, w_bit, op32);
	// reg field, always decoded when a mod r/m byte is present
	reg_sel_d = f_reg;
	reg_size_d = has_modrm ? gr_size(w_present, w_bit, op32) : `XOFD_SZ_NONE;
	// register operand form
	if (has_modrm && (f_mod == `XOFD_MOD_REG)) begin
		rm_is_reg_d = 1'b1;
		rm_reg_d = f_rm;
		rm_size_d = gr_size(w_present, w_bit, op32);
	end
	// memory forms, 16-bit addressing
	if (mem_form && !addr32) begin
		if ((f_mod == `XOFD_MOD_NODISP) && (f_rm == `XOFD_RM16_DIRECT)) begin
			direct_addr_d = 1'b1;
			disp_len_d = `XOFD_LEN_16;
		end else begin
			case (f_rm)
				3'h0: begin
					base_valid_d = 1'b1;
					base_reg_d = `XOFD_GR_BX;
					index_valid_d = 1'b1;
					index_reg_d = `XOFD_GR_SI;
				end
				3'h1: begin
					base_valid_d = 1'b1;
					base_reg_d = `XOFD_GR_BX;
					index_valid_d = 1'b1;
					index_reg_d = `XOFD_GR_DI;
				end
				3'h2: begin
					base_valid_d = 1'b1;
					base_reg_d = `XOFD_GR_BP;
					index_valid_d = 1'b1;
					index_reg_d = `XOFD_GR_SI;
				end
				3'h3: begin
					base_valid_d = 1'b1;
					base_reg_d = `XOFD_GR_BP;
					index_valid_d = 1'b1;
					index_reg_d = `XOFD_GR_DI;
				end
				3'h4: begin
					index_valid_d = 1'b1;
					index_reg_d = `XOFD_GR_SI;
				end
				3'h5: begin
					index_valid_d = 1'b1;
					index_reg_d = `XOFD_GR_DI;
				end
				3'h6: begin
					base_valid_d = 1'b1;
					base_reg_d = `XOFD_GR_BP;
				end
				default: begin
					base_valid_d = 1'b1;
					base_reg_d = `XOFD_GR_BX;
				end
			endcase
			// any BP base defaults to the stack segment
			seg_stack_d = base_valid_d && (base_reg_d == `XOFD_GR_BP);
			if (f_mod == `XOFD_MOD_DISP8) begin
				disp_len_d = `XOFD_LEN_8;
			end else if (f_mod == `XOFD_MOD_DISPW) begin
				disp_len_d = `XOFD_LEN_16;
			end
		end
	end
	// memory forms, 32-bit addressing
	if (mem_form && addr32) begin
		if ((f_mod == `XOFD_MOD_NODISP) && (f_rm == `XOFD_RM32_DIRECT)) begin
			direct_addr_d = 1'b1;
			disp_len_d = `XOFD_LEN_32;
		end else begin
			if (f_rm == `XOFD_RM32_SIB) begin
				sib_expected_d = 1'b1;
			end else begin
				base_valid_d = 1'b1;
				base_reg_d = f_rm;
				seg_stack_d = (f_rm == `XOFD_GR_BP);
			end
			if (f_mod == `XOFD_MOD_DISP8) begin
				disp_len_d = `XOFD_LEN_8;
			end else if (f_mod == `XOFD_MOD_DISPW) begin
				disp_len_d = `XOFD_LEN_32;
			end
		end
	end
end

// immediate, direction and special register decode
always @* begin
	imm_len_d = `XOFD_LEN_0;
	imm_sext_d = 1'b0;
	if (has_imm) begin
		if (s_bit) begin
			imm_len_d = `XOFD_LEN_8;
			imm_sext_d = 1'b1;
		end else if (w_present && !w_bit) begin
			imm_len_d = `XOFD_LEN_8;
		end else if (op32) begin
			imm_len_d = `XOFD_LEN_32;
		end else begin
			imm_len_d = `XOFD_LEN_16;
		end
	end
	src_is_rm_d = d_bit;
	spec_valid_d = 1'b0;
	spec_num_d = `XOFD_RST_3;
	spec_invalid_d = 1'b0;
	if (spec_mov) begin
		if (spec_ok(spec_class, f_reg)) begin
			spec_valid_d = 1'b1;
			spec_num_d = f_reg;
		end else begin
			spec_invalid_d = 1'b1;
		end
	end
end

// result register, one cycle after the request
always @(posedge core_clk or negedge resetn) begin
	if (!resetn) begin
		out_valid <= `XOFD_RST_1;
		rm_is_reg <= `XOFD_RST_1;
		rm_reg <= `XOFD_RST_3;
		rm_size <= `XOFD_RST_2;
		reg_sel <= `XOFD_RST_3;
		reg_size <= `XOFD_RST_2;
		op_size <= `XOFD_RST_2;
		base_valid <= `XOFD_RST_1;
		base_reg <= `XOFD_RST_3;
		index_valid <= `XOFD_RST_1;
		index_reg <= `XOFD_RST_3;
		direct_addr <= `XOFD_RST_1;
		seg_stack <= `XOFD_RST_1;
		sib_expected <= `XOFD_RST_1;
		disp_len <= `XOFD_RST_2;
		imm_len <= `XOFD_RST_2;
		imm_sext <= `XOFD_RST_1;
		src_is_rm <= `XOFD_RST_1;
		spec_valid <= `XOFD_RST_1;
		spec_num <= `XOFD_RST_3;
		spec_invalid <= `XOFD_RST_1;
	end else begin
		out_valid <= in_valid;
		if (in_valid) begin
			rm_is_reg <= rm_is_reg_d;
			rm_reg <= rm_reg_d;
			rm_size <= rm_size_d;
			reg_sel <= reg_sel_d;
			reg_size <= reg_size_d;
			op_size <= op_size_d;
			base_valid <= base_valid_d;
			base_reg <= base_reg_d;
			index_valid <= index_valid_d;
			index_reg <= index_reg_d;
			direct_addr <= direct_addr_d;
			seg_stack <= seg_stack_d;
			sib_expected <= sib_expected_d;
			disp_len <= disp_len_d;
			imm_len <= imm_len_d;
			imm_sext <= imm_sext_d;
			src_is_rm <= src_is_rm_d;
			spec_valid <= spec_valid_d;
			spec_num <= spec_num_d;
			spec_invalid <= spec_invalid_d;
		end
	end
end

endmodule // xofd_decoder
`default_nettype wire

// *** dv/xofd_checker.sv ***
// assertions on the decoder ports
`timescale 1ns/10ps
`default_nettype none
module xofd_checker (
	// clock, reset, request
	input wire logic core_clk, resetn, in_valid, has_modrm, addr32, op32,
	input wire logic w_present, w_bit, d_bit, s_bit, has_imm,
	input wire logic [7:0] modrm,
	// result
	input wire logic out_valid, rm_is_reg, sib_expected, seg_stack, imm_sext,
	input wire logic src_is_rm, spec_valid, spec_invalid,
	input wire logic [1:0] disp_len, op_size
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire mem = in_valid && has_modrm && modrm[7:6] != 2'h3;
	a_answer_next: assert property (in_valid |=> out_valid) else $error("late");
	a_idle_hold: assert property (!in_valid |=> !out_valid && $stable(disp_len))
		else $error("hold");
	a_sib_follows: assert property (mem && addr32 && modrm[2:0] == 3'h4 |=> sib_expected)
		else $error("sib");
	a_disp_byte: assert property (mem && modrm[7:6] == 2'h1 |=> disp_len == 2'h1)
		else $error("d8");
	a_disp_wide: assert property (mem && modrm[7:6] == 2'h2 |=> disp_len == {1'b1, $past(addr32)})
		else $error("dw");
	a_bp_stack: assert property (mem && !addr32 && modrm[7:6] != 2'h0 && modrm[2:0] == 3'h6
		|=> seg_stack) else $error("seg");
	a_reg_operand: assert property (in_valid && has_modrm && modrm[7:6] == 2'h3
		|=> rm_is_reg && disp_len == 2'h0) else $error("reg");
	a_byte_width: assert property (in_valid && w_present && !w_bit |=> op_size == 2'h1)
		else $error("w");
	a_full_size: assert property (in_valid && !w_present |=> op_size == {1'b1, $past(op32)})
		else $error("full");
	a_imm_sext: assert property (in_valid && has_imm |=> imm_sext == $past(s_bit))
		else $error("sext");
	a_direction: assert property (in_valid |=> src_is_rm == $past(d_bit))
		else $error("dir");
	a_spec_exclusive: assert property (out_valid |-> !(spec_valid && spec_invalid))
		else $error("spec");
	c_sib: cover property (mem && addr32 && modrm[2:0] == 3'h4);
	c_bad_sel: cover property (out_valid && spec_invalid);
	c_reg: cover property (out_valid && rm_is_reg);
endmodule // xofd_checker
`default_nettype wire

// *** dv/xofd_prefetch.sv ***
// prefetch model: one packed request a cycle
`timescale 1ns/10ps
`default_nettype none
module xofd_prefetch (
	// clock
	input wire logic core_clk,
	// valid, modrm, flags, class
	output var logic [19:0] req
);
	initial req = 20'h0;
	task send(input logic [18:0] f);
		@(negedge core_clk);
		req = {1'b1, f};
	endtask
	// released fields flip so stale values never match
	task idle();
		@(negedge core_clk);
		req = {1'b0, ~req[18:0]};
	endtask
endmodule // xofd_prefetch
`default_nettype wire

// *** dv/xofd_decoder_bench.sv ***
// bench for the operand field decoder
`timescale 1ns/10ps
`default_nettype none
module xofd_decoder_bench;
	logic core_clk = 0;
	logic resetn = 0;
	logic [31:0] rnd;
	logic [34:0] exp_q[$];
	integer mismatches = 0, samples_checked = 0, seed = 32'ha710, i, k;
	wire [19:0] req;
	wire out_valid, rm_is_reg, seg_stack, sib_expected, imm_sext, src_is_rm, spec_valid, spec_invalid;
	wire base_valid, index_valid, direct_addr;
	wire [1:0] disp_len, op_size, reg_size, imm_len, rm_size;
	wire [2:0] spec_num, rm_reg, reg_sel, base_reg, index_reg;
	wire [34:0] got = {rm_is_reg, disp_len, seg_stack, sib_expected, op_size, reg_size, imm_len,
		imm_sext, src_is_rm, spec_valid, spec_num, spec_invalid, rm_reg, rm_size, reg_sel,
		base_valid, base_reg, index_valid, index_reg, direct_addr};
	always #2.5 core_clk = ~core_clk;
	xofd_prefetch u_xofd_prefetch (.core_clk(core_clk), .req(req));
	xofd_decoder u_xofd_decoder (.core_clk(core_clk), .resetn(resetn), .in_valid(req[19]),
		.modrm(req[18:11]), .has_modrm(req[10]), .op32(req[9]), .addr32(req[8]),
		.w_present(req[7]), .w_bit(req[6]), .d_bit(req[5]), .s_bit(req[4]), .has_imm(req[3]),
		.spec_mov(req[2]), .spec_class(req[1:0]), .out_valid(out_valid), .rm_is_reg(rm_is_reg),
		.rm_reg(rm_reg), .rm_size(rm_size), .reg_sel(reg_sel), .reg_size(reg_size),
		.op_size(op_size), .base_valid(base_valid), .base_reg(base_reg),
		.index_valid(index_valid), .index_reg(index_reg), .direct_addr(direct_addr),
		.seg_stack(seg_stack), .sib_expected(sib_expected), .disp_len(disp_len),
		.imm_len(imm_len), .imm_sext(imm_sext), .src_is_rm(src_is_rm),
		.spec_valid(spec_valid), .spec_num(spec_num), .spec_invalid(spec_invalid));
	function automatic logic [34:0] expect_of(input logic [18:0] f);
		logic [1:0] md, os, dl;
		logic [2:0] rm, rg, br, ir;
		logic mm, sb, ok, sg, rr, dr, bv, iv;
		md = f[18:17];
		rg = f[16:14];
		rm = f[13:11];
		mm = f[10] && md != 2'h3;
		sb = mm && f[8] && rm == 3'h4;
		rr = f[10] && md == 2'h3;
		dr = mm && md == 2'h0 && rm == (f[8] ? 3'h5 : 3'h6);
		bv = mm && !dr && !sb && (f[8] || (rm != 3'h4 && rm != 3'h5));
		br = !bv ? 3'h0 : f[8] ? rm : (rm == 3'h2 || rm == 3'h3 || rm == 3'h6) ? 3'h5 : 3'h3;
		iv = mm && !f[8] && rm < 3'h6;
		ir = !iv ? 3'h0 : rm[0] ? 3'h7 : 3'h6;
		os = (f[7] && !f[6]) ? 2'h1 : {1'b1, f[9]};
		dl = !mm ? 2'h0 : md == 2'h1 ? 2'h1 : md == 2'h2 ? {1'b1, f[8]}
			: f[8] ? {2{rm == 3'h5}} : {rm == 3'h6, 1'b0};
		sg = mm && !sb && (f[8] ? rm == 3'h5 && md != 2'h0
			: rm == 3'h2 || rm == 3'h3 || (rm == 3'h6 && md != 2'h0));
		ok = f[2] && f[1:0] != 2'h3 && (f[1] ? rg > 3'h2 : f[0] ? rg != 3'h4 && rg != 3'h5
			: rg == 3'h0 || (rg > 3'h1 && rg < 3'h5));
		return {rr, dl, sg, sb, os, f[10] ? os : 2'h0,
			f[3] ? (f[4] ? 2'h1 : os) : 2'h0, f[3] && f[4], f[5], ok, ok ? rg : 3'h0, f[2] && !ok,
			rr ? rm : 3'h0, rr ? os : 2'h0, rg, bv, br, iv, ir, dr};
	endfunction
	task cmp(input logic [34:0] e, input logic [34:0] g);
		samples_checked++;
		if (e !== g) begin
			mismatches++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task put(input logic [18:0] f);
		u_xofd_prefetch.send(f);
		exp_q.push_back(expect_of(f));
	endtask
	task tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task drain(input string name);
		u_xofd_prefetch.idle();
		for (k = 0; k < 20 && exp_q.size() > 0; k++)
			@(negedge core_clk);
		if (exp_q.size() != 0) begin
			mismatches++;
			tally_and_finish;
		end else begin
			$display("test %s done", name);
		end
	endtask
	always @(negedge core_clk) begin
		if (out_valid === 1'b1 && exp_q.size() > 0)
			cmp(exp_q.pop_front(), got);
		else if (out_valid !== 1'b0)
			cmp(35'h0, {34'h0, 1'b1});
	end
	initial begin
		repeat (10) @(negedge core_clk);
		resetn = 1;
		@(negedge core_clk);
		cmp(35'h0, got | {34'h0, out_valid});
		$display("test reset done");
		for (i = 0; i < 512; i++)
			put({i[7:0], 1'b1, i[4], i[8], 8'hC8});
		drain("address maps");
		for (i = 0; i < 32; i++)
			put({2'h3, i[2:0], 3'h0, 3'h4, 5'h0, 1'b1, i[4:3]});
		drain("special select");
		for (i = 0; i < 400; i++) begin
			rnd = $random(seed);
			put(rnd[18:0]);
		end
		drain("random mix");
		tally_and_finish;
	end
endmodule // xofd_decoder_bench
bind xofd_decoder xofd_checker u_xofd_checker (.core_clk(core_clk), .resetn(resetn),
	.in_valid(in_valid), .has_modrm(has_modrm), .addr32(addr32), .op32(op32),
	.w_present(w_present), .w_bit(w_bit), .d_bit(d_bit), .s_bit(s_bit), .has_imm(has_imm),
	.modrm(modrm), .out_valid(out_valid), .rm_is_reg(rm_is_reg), .sib_expected(sib_expected),
	.seg_stack(seg_stack), .imm_sext(imm_sext), .src_is_rm(src_is_rm),
	.spec_valid(spec_valid), .spec_invalid(spec_invalid), .disp_len(disp_len),
	.op_size(op_size));
`default_nettype wire
